/* shared/axis_defines.svh */
`ifndef AXIS_DEFINES_SVH
`define AXIS_DEFINES_SVH

// register byte offsets
`define REG_ADDR_WORD 12'h000
`define REG_STATUS 12'h004
`define REG_CTRL 12'h008
`define REG_INT_STATUS 12'h00C
`define REG_INT_MASK 12'h010

// status register fields
`define ST_ADDR_LSB 0
`define ST_MODE_BIT 8
`define ST_LSS_BIT 9
`define ST_LED_LSB 16

// control register fields and reset value
`define CTRL_FLASH_EN_BIT 0
`define CTRL_LED_TEST_BIT 1
`define CTRL_RESET 2'h1

// interrupt event bits
`define EV_SEL_CHANGE 0
`define EV_DRIVE_ERR 1
`define EV_READY 2
`define EV_FB_ERR 3
`define EV_WIDTH 4

// decode constants
`define HIGH_FIELD_WEIGHT 64
`define MID_FIELD_WEIGHT 8
`define MODE_OFFSET 128
`define UNSET_ADDRESS 8'hFF

// timing
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define FLASH_PERIOD_MS 1000
`define FLASH_HALF_TICKS (`FLASH_PERIOD_MS / 2)
`define ACT_BLANK_MS 50

`endif

/* shared/axis_pkg.sv */
package axis_pkg;

  typedef logic [11:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;

  typedef enum logic {
    MODE_CANOPEN,
    MODE_PROP_CAN
  } bus_mode_e;

  typedef enum logic [1:0] {
    RDY_INIT,
    RDY_ON,
    RDY_LSS_FLASH,
    RDY_FAULT
  } ready_state_e;

  typedef struct packed {
    logic [2:0] axis_sel_high;
    logic [2:0] axis_sel_mid;
    logic [2:0] axis_sel_low;
  } sel_fields_s;

  typedef struct packed {
    logic in_link_up;
    logic in_activity;
    logic out_link_up;
    logic out_activity;
    logic run_state;
    logic err_state;
  } fieldbus_stat_s;

endpackage : axis_pkg

/* design/sel_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sel_sync (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire axis_pkg::sel_fields_s pins, // raw selection inputs
  output axis_pkg::sel_fields_s stable // filtered selection value
);
  import axis_pkg::*;

  sel_fields_s s1_r;
  sel_fields_s s2_r;
  sel_fields_s s3_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      stable <= '0;
    end else if (s2_r == s3_r) begin
      stable <= s3_r; // R14
    end
  end

endmodule : sel_sync

`default_nettype wire

/* design/axis_address_decode_status.sv */
// Function
// R1: middle high-field bit one selects proprietary CAN
// R2: middle high-field bit zero selects CANopen
// R3: top high-field bit ignored, taken as zero
// R4: address uses bits 0 to 6, max 127
// R5: CANopen address is 64*high+8*mid+low
// R6: proprietary mode removes 128 from high contribution
// R7: all fields zero: address 255, CANopen, LSS inactive
// R8: LSS inactive flashes ready indicator, one-second period
// R9: error output high while drive error present
// R10: ready high after init, low on error
// R11: input-port link and activity indicator
// R12: output-port link and activity indicator
// R13: separate fieldbus run and error indicators
// R14: three 3-bit selection fields form address word
//
// Our own choices: the address map and the APB register port.
`include "axis_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module axis_address_decode_status #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire axis_pkg::apb_addr_t paddr, // apb byte address
  input wire axis_pkg::apb_data_t pwdata, // apb write data
  output axis_pkg::apb_data_t prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire axis_pkg::sel_fields_s sel_pins, // selection straps
  input wire logic init_done, // drive initialisation finished
  input wire logic drive_fault, // drive error condition
  input wire axis_pkg::fieldbus_stat_s fb_stat, // fieldbus stack status
  output logic [7:0] axis_address, // decoded axis address
  output logic proprietary_can_mode, // protocol mode select
  output logic lss_inactive, // default address state
  output logic drive_ready_out, // green ready indicator
  output logic drive_error_out, // red error indicator
  output logic fieldbus_in_link_act, // input-port link indicator
  output logic fieldbus_out_link_act, // output-port link indicator
  output logic fieldbus_run_out, // fieldbus run indicator
  output logic fieldbus_error_out, // fieldbus error indicator
  output logic irq // level interrupt
);
  import axis_pkg::*;

  localparam int unsigned HALF_TICKS = `FLASH_HALF_TICKS;
  localparam int unsigned BLANK_TICKS = `ACT_BLANK_MS;

  sel_fields_s sel_stable;
  logic [8:0] addr_word_r;
  logic addr_valid_r;
  logic [7:0] addr_nxt;
  bus_mode_e mode_nxt;
  logic lss_nxt;
  logic [1:0] ctrl_r;
  logic [`EV_WIDTH-1:0] int_status_r;
  logic [`EV_WIDTH-1:0] int_mask_r;
  logic [`EV_WIDTH-1:0] events;
  logic [15:0] tick_cnt_r;
  logic tick;
  logic [8:0] flash_cnt_r;
  logic flash_phase_r;
  logic [5:0] blank_in_r;
  logic [5:0] blank_out_r;
  ready_state_e rdy_state_r;
  logic ready_lvl;
  logic drive_fault_d_r;
  logic ready_d_r;
  logic fb_err_d_r;
  logic wr_en;
  logic [`EV_WIDTH-1:0] w1c;

  sel_sync u_sel_sync (
    .clk(clk),
    .rst(rst),
    .pins(sel_pins),
    .stable(sel_stable)
  );

  // blanking count for a link-activity indicator
  function automatic logic [5:0] blank_next(input logic [5:0] cnt, input logic link,
                                            input logic act, input logic tk);
    if (!link) begin
      blank_next = 6'h0;
    end else if (cnt == 6'h0) begin
      blank_next = act ? BLANK_TICKS[5:0] : 6'h0;
    end else if (tk) begin
      blank_next = cnt - 6'h1;
    end else begin
      blank_next = cnt;
    end
  endfunction : blank_next

  // address and mode decode
  always_comb begin
    logic [8:0] hi_term;
    hi_term = '0;
    addr_nxt = '0;
    mode_nxt = MODE_CANOPEN;
    lss_nxt = 1'b0;
    if (sel_stable == '0) begin
      addr_nxt = `UNSET_ADDRESS; // R7
      mode_nxt = MODE_CANOPEN; // R7
      lss_nxt = 1'b1; // R7
    end else begin
      // top bit of the high field dropped
      hi_term = 9'(`HIGH_FIELD_WEIGHT * {1'b0, sel_stable.axis_sel_high[1:0]}); // R3
      if (sel_stable.axis_sel_high[1]) begin
        mode_nxt = MODE_PROP_CAN; // R1
        hi_term = 9'(hi_term - 9'(`MODE_OFFSET)); // R6
      end else begin
        mode_nxt = MODE_CANOPEN; // R2
      end
      addr_nxt = {1'b0, 7'(hi_term // R5
                           + 9'(`MID_FIELD_WEIGHT * sel_stable.axis_sel_mid)
                           + 9'(sel_stable.axis_sel_low))}; // R4
    end
  end

  // decoded address, mode and raw word
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_word_r <= '0;
      addr_valid_r <= 1'b0;
      axis_address <= `UNSET_ADDRESS;
      proprietary_can_mode <= 1'b0;
      lss_inactive <= 1'b1;
    end else begin
      addr_word_r <= {sel_stable.axis_sel_high, sel_stable.axis_sel_mid,
                      sel_stable.axis_sel_low}; // R14
      addr_valid_r <= 1'b1;
      axis_address <= addr_nxt;
      proprietary_can_mode <= (mode_nxt == MODE_PROP_CAN);
      lss_inactive <= lss_nxt;
    end
  end

  // millisecond enable
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h1;
    end
  end

  // half-second flash phase
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_cnt_r <= '0;
      flash_phase_r <= 1'b0;
    end else if (tick) begin
      if (flash_cnt_r == 9'(HALF_TICKS - 1)) begin
        flash_cnt_r <= '0;
        flash_phase_r <= ~flash_phase_r; // R8
      end else begin
        flash_cnt_r <= flash_cnt_r + 9'h1;
      end
    end
  end

  // ready indicator state
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_state_r <= RDY_INIT;
    end else if (drive_fault) begin
      rdy_state_r <= RDY_FAULT; // R10
    end else begin
      unique case (rdy_state_r)
        RDY_INIT, RDY_FAULT: begin
          if (init_done) begin
            rdy_state_r <= lss_inactive ? RDY_LSS_FLASH : RDY_ON; // R10
          end
        end
        RDY_ON: begin
          if (lss_inactive) begin
            rdy_state_r <= RDY_LSS_FLASH;
          end
        end
        RDY_LSS_FLASH: begin
          if (!lss_inactive) begin
            rdy_state_r <= RDY_ON;
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (rdy_state_r)
      RDY_ON: ready_lvl = 1'b1;
      RDY_LSS_FLASH: ready_lvl = ctrl_r[`CTRL_FLASH_EN_BIT] ? flash_phase_r : 1'b1; // R8
      RDY_INIT, RDY_FAULT: ready_lvl = 1'b0;
    endcase
  end

  // activity blanking
  always_ff @(posedge clk) begin
    if (rst) begin
      blank_in_r <= '0;
      blank_out_r <= '0;
    end else begin
      blank_in_r <= blank_next(blank_in_r, fb_stat.in_link_up, fb_stat.in_activity, tick);
      blank_out_r <= blank_next(blank_out_r, fb_stat.out_link_up, fb_stat.out_activity, tick);
    end
  end

  // indicator outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_ready_out <= 1'b0;
      drive_error_out <= 1'b0;
      fieldbus_in_link_act <= 1'b0;
      fieldbus_out_link_act <= 1'b0;
      fieldbus_run_out <= 1'b0;
      fieldbus_error_out <= 1'b0;
    end else if (ctrl_r[`CTRL_LED_TEST_BIT]) begin
      drive_ready_out <= 1'b1;
      drive_error_out <= 1'b1;
      fieldbus_in_link_act <= 1'b1;
      fieldbus_out_link_act <= 1'b1;
      fieldbus_run_out <= 1'b1;
      fieldbus_error_out <= 1'b1;
    end else begin
      drive_ready_out <= ready_lvl && !drive_fault; // R10
      drive_error_out <= drive_fault; // R9
      fieldbus_in_link_act <= fb_stat.in_link_up && (blank_in_r == 6'h0); // R11
      fieldbus_out_link_act <= fb_stat.out_link_up && (blank_out_r == 6'h0); // R12
      fieldbus_run_out <= fb_stat.run_state; // R13
      fieldbus_error_out <= fb_stat.err_state; // R13
    end
  end

  // event edges
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_fault_d_r <= 1'b0;
      ready_d_r <= 1'b0;
      fb_err_d_r <= 1'b0;
    end else begin
      drive_fault_d_r <= drive_fault;
      ready_d_r <= (rdy_state_r == RDY_ON) || (rdy_state_r == RDY_LSS_FLASH);
      fb_err_d_r <= fb_stat.err_state;
    end
  end

  always_comb begin
    events = '0;
    events[`EV_SEL_CHANGE] = addr_valid_r && (addr_word_r != {sel_stable.axis_sel_high,
                             sel_stable.axis_sel_mid, sel_stable.axis_sel_low});
    events[`EV_DRIVE_ERR] = drive_fault && !drive_fault_d_r;
    events[`EV_READY] = !ready_d_r && ((rdy_state_r == RDY_ON) || (rdy_state_r == RDY_LSS_FLASH));
    events[`EV_FB_ERR] = fb_stat.err_state && !fb_err_d_r;
  end

  // apb slave, one wait-free access
  assign wr_en = psel && penable && pready && pwrite;
  assign w1c = (wr_en && paddr == `REG_INT_STATUS) ? pwdata[`EV_WIDTH-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RESET;
      int_mask_r <= '0;
    end else if (wr_en) begin
      if (paddr == `REG_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
      if (paddr == `REG_INT_MASK) begin
        int_mask_r <= pwdata[`EV_WIDTH-1:0];
      end
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= (int_status_r & ~w1c) | events;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_r & int_mask_r);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= '0;
      unique case (paddr)
        `REG_ADDR_WORD: prdata <= {23'h0, addr_word_r};
        `REG_STATUS: prdata <= {10'h0, fieldbus_error_out, fieldbus_run_out,
                                fieldbus_out_link_act, fieldbus_in_link_act,
                                drive_error_out, drive_ready_out, 6'h0, lss_inactive,
                                proprietary_can_mode, axis_address};
        `REG_CTRL: prdata <= {30'h0, ctrl_r};
        `REG_INT_STATUS: prdata <= {28'h0, int_status_r};
        `REG_INT_MASK: prdata <= {28'h0, int_mask_r};
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : axis_address_decode_status

`default_nettype wire

/* bench/strap_model.sv */
`timescale 1ns/1ps
`default_nettype none

module strap_model (
  input wire logic clk, // clock
  input wire axis_pkg::sel_fields_s want, // strap setting
  input wire logic glitch, // one-cycle upset
  output var axis_pkg::sel_fields_s pins // pin levels
);
  import axis_pkg::*;
  always_ff @(posedge clk) begin
    pins <= glitch ? ~want : want;
  end
endmodule : strap_model

`default_nettype wire

/* bench/axis_asserts.sv */
`include "axis_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module axis_asserts (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire axis_pkg::apb_addr_t paddr, // apb address
  input wire axis_pkg::apb_data_t pwdata, // apb write data
  input wire axis_pkg::sel_fields_s sel_pins, // straps
  input wire logic drive_fault, // fault
  input wire axis_pkg::fieldbus_stat_s fb_stat, // stack status
  input wire logic [7:0] axis_address, // address
  input wire logic proprietary_can_mode, // mode
  input wire logic lss_inactive, // default state
  input wire logic drive_ready_out, // ready led
  input wire logic drive_error_out, // error led
  input wire logic fieldbus_in_link_act, // in link led
  input wire logic fieldbus_out_link_act, // out link led
  input wire logic fieldbus_run_out, // run led
  input wire logic fieldbus_error_out // fb error led
);
  import axis_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // led test forces every indicator, tracked from bus writes
  logic led_test_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      led_test_r <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == `REG_CTRL) begin
      led_test_r <= pwdata[`CTRL_LED_TEST_BIT];
    end
  end
  sequence sel_steady;
    $stable(sel_pins) [*8];
  endsequence
  a_mode_select:
    assert property (sel_steady |-> proprietary_can_mode == sel_pins.axis_sel_high[1])
    else $error("mode wrong");
  a_addr_decode:
    assert property (sel_steady |-> axis_address == ((sel_pins == 9'h0) ? 8'hff :
      {1'b0, sel_pins.axis_sel_high[0], sel_pins.axis_sel_mid, sel_pins.axis_sel_low}))
    else $error("address wrong");
  a_default_state:
    assert property (lss_inactive |-> axis_address == 8'hff && !proprietary_can_mode)
    else $error("default state wrong");
  a_lss_from_pins:
    assert property (sel_steady |-> lss_inactive == (sel_pins == 9'h0))
    else $error("default state not from pins");
  a_error_follow:
    assert property (!led_test_r |=> drive_error_out == $past(drive_fault))
    else $error("error led wrong");
  a_ready_drop:
    assert property (drive_fault && !led_test_r |=> !drive_ready_out)
    else $error("ready not dropped");
  a_run_err_follow:
    assert property (!led_test_r |=> fieldbus_run_out == $past(fb_stat.run_state)
      && fieldbus_error_out == $past(fb_stat.err_state))
    else $error("run or error led wrong");
  a_in_link_off:
    assert property (!fb_stat.in_link_up && !led_test_r |=> !fieldbus_in_link_act)
    else $error("in link led on");
  a_out_link_off:
    assert property (!fb_stat.out_link_up && !led_test_r |=> !fieldbus_out_link_act)
    else $error("out link led on");
  a_led_test_all:
    assert property (led_test_r |=> drive_ready_out && drive_error_out
      && fieldbus_in_link_act && fieldbus_out_link_act
      && fieldbus_run_out && fieldbus_error_out)
    else $error("led test not lighting all");
endmodule : axis_asserts

bind axis_address_decode_status axis_asserts u_chk (
  .clk, .rst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
  .sel_pins, .drive_fault, .fb_stat, .axis_address, .proprietary_can_mode,
  .lss_inactive, .drive_ready_out, .drive_error_out, .fieldbus_in_link_act,
  .fieldbus_out_link_act, .fieldbus_run_out, .fieldbus_error_out
);

`default_nettype wire

/* bench/testbench.sv */
`include "axis_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end

module testbench;
  import axis_pkg::*;
  localparam int TK = 4;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, init_done = 0, drive_fault = 0, glitch = 0;
  logic mode, lss, rdy, err, inl, outl, run, fbe, irq;
  logic [7:0] addr;
  apb_addr_t paddr = 0;
  apb_data_t pwdata = 0, prdata;
  sel_fields_s want = 0, sel_pins;
  fieldbus_stat_s fb_stat = 0;
  logic [8:0] tbl[4] = '{9'h1ff, 9'h080, 9'h100, 9'h0c0};
  logic [32:0] expq[$];
  logic [32:0] got_v, exp_v;
  int n_errors = 0, cmp_count = 0, n;

  axis_address_decode_status #(.TICK_CYCLES(TK)) DUT (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sel_pins, .init_done, .drive_fault, .fb_stat, .axis_address(addr),
    .proprietary_can_mode(mode), .lss_inactive(lss), .drive_ready_out(rdy),
    .drive_error_out(err), .fieldbus_in_link_act(inl), .fieldbus_out_link_act(outl),
    .fieldbus_run_out(run), .fieldbus_error_out(fbe), .irq
  );
  strap_model u_straps (.clk, .want, .glitch, .pins(sel_pins));

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic apb_data_t st(sel_fields_s p, logic [5:0] ind);
    int h, a;
    h = p.axis_sel_high & 3;
    a = 64 * h + 8 * p.axis_sel_mid + p.axis_sel_low;
    if (h >= 2) a = a - 128;
    if (p == 0) a = 255;
    return {10'h0, ind, 6'h0, p == 0, h >= 2, a[7:0]};
  endfunction : st

  task automatic cyc(int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic apb(logic wr, apb_addr_t a, apb_data_t d, logic [32:0] e);
    expq.push_back(e);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic rd_st(logic [5:0] ind);
    apb(0, `REG_STATUS, 0, {1'b0, st(want, ind)});
  endtask : rd_st

  task automatic reset_dut;
    rst <= 1;
    cyc(5);
    rst <= 0;
  endtask : reset_dut

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    if ((psel & penable & pready) === 1'b1) begin
      got_v = {pslverr, pwrite ? 32'h0 : prdata};
      exp_v = expq.pop_front();
      `CHK(got_v, exp_v)
    end
  end

  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h5f9f));
    reset_dut();
    rd_st(6'h0);
    apb(0, `REG_CTRL, 0, 33'h1);
    apb(0, `REG_INT_MASK, 0, 33'h0);
    apb(1, 12'h014, 32'h5, {1'b1, 32'h0});
    apb(0, 12'h014, 0, {1'b1, 32'h0});
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      want <= (i < 4) ? tbl[i] : 9'($urandom);
      cyc(12);
      apb(0, `REG_ADDR_WORD, 0, {24'h0, want});
      rd_st(6'h0);
    end
    glitch <= 1;
    cyc(1);
    glitch <= 0;
    cyc(10);
    apb(0, `REG_ADDR_WORD, 0, {24'h0, want});
    $display("test decode done");
    apb(0, `REG_INT_STATUS, 0, 33'h1);
    apb(1, `REG_INT_MASK, 32'h1, 33'h0);
    cyc(2);
    `CHK(irq, 1'b1)
    apb(1, `REG_INT_STATUS, 32'h1, 33'h0);
    cyc(2);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    want <= 9'h02a;
    init_done <= 1;
    cyc(12);
    rd_st(6'h01);
    drive_fault <= 1;
    init_done <= 0;
    cyc(4);
    rd_st(6'h02);
    drive_fault <= 0;
    cyc(2);
    init_done <= 1;
    cyc(4);
    rd_st(6'h01);
    apb(0, `REG_INT_STATUS, 0, 33'h7);
    $display("test ready done");
    for (int i = 0; i < 16; i++) begin
      fb_stat <= {i[3], 1'b0, i[2], 1'b0, i[1:0]};
      cyc(4);
      rd_st({i[0], i[1], i[2], i[3], 2'b01});
    end
    fb_stat <= 6'b11_1100;
    cyc(1);
    fb_stat <= 6'b10_1000;
    cyc(4);
    rd_st(6'h01);
    cyc(60 * TK);
    rd_st(6'h0d);
    apb(1, `REG_CTRL, 32'h3, 33'h0);
    rd_st(6'h3f);
    apb(1, `REG_CTRL, 32'h1, 33'h0);
    $display("test fieldbus done");
    want <= 0;
    fb_stat <= 0;
    init_done <= 0;
    reset_dut();
    cyc(12);
    rd_st(6'h0);
    init_done <= 1;
    for (int s = 0; s < 4; s++) begin
      n = 0;
      while ((rdy === 1'b1) == s[0] && n < 3000) begin
        @(posedge clk);
        n++;
      end
    end
    `CHK(n, 500 * TK)
    apb(1, `REG_CTRL, 32'h0, 33'h0);
    cyc(2);
    n = 0;
    while (rdy === 1'b1 && n < 2500) begin
      @(posedge clk);
      n++;
    end
    `CHK(n, 2500)
    $display("test flash done");
    finish_test();
  end
endmodule : testbench

`default_nettype wire
